// File: src/motion_event_pkg.sv
// Package: register map, field layout and carrier types of the motion event generators
package motion_event_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] GEN1_CONFIG_ADDR = 8'h30;
	localparam logic [7:0] GEN1_FLAGS_ADDR = 8'h31;
	localparam logic [7:0] GEN1_THRESHOLD_ADDR = 8'h32;
	localparam logic [7:0] GEN1_DURATION_ADDR = 8'h33;
	localparam logic [7:0] GEN2_CONFIG_ADDR = 8'h34;
	localparam logic [7:0] GEN2_FLAGS_ADDR = 8'h35;
	localparam logic [7:0] GEN2_THRESHOLD_ADDR = 8'h36;
	localparam logic [7:0] GEN2_DURATION_ADDR = 8'h37;
	localparam logic [7:0] GEN_ADDR_STRIDE = 8'h04;

	// ----------------------------------------
	// Field layout and reset values
	// ----------------------------------------
	localparam int FIELD_W = 7;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] ROUTE_OWN = 2'h0;
	localparam logic [1:0] ROUTE_EITHER = 2'h1;
	localparam logic [1:0] ROUTE_DATA_READY = 2'h2;
	localparam logic [1:0] ROUTE_BOOT = 2'h3;

	// Configuration register, bit 7 down to bit 0
	typedef struct packed {
		logic and_or_select;
		logic six_direction_enable;
		logic z_high_enable;
		logic z_low_enable;
		logic y_high_enable;
		logic y_low_enable;
		logic x_high_enable;
		logic x_low_enable;
	} gen_config_t;

	// Source register, bit 7 down to bit 0
	typedef struct packed {
		logic zero_bit;
		logic event_active;
		logic z_high_flag;
		logic z_low_flag;
		logic y_high_flag;
		logic y_low_flag;
		logic x_high_flag;
		logic x_low_flag;
	} gen_flags_t;

	// One output sample of the three axes, two's complement
	typedef struct packed {
		logic sample_valid;
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} axis_sample_t;
endpackage : motion_event_pkg

// File: src/motion_event_unit.sv
// One motion event generator: compare, combine, duration count and source flags
module motion_event_unit #(
	parameter int SAMPLE_W = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire motion_event_pkg::axis_sample_t i_sample,
	input wire logic [1:0] i_full_scale,
	input wire motion_event_pkg::gen_config_t i_config,
	input wire logic [6:0] i_threshold_level,
	input wire logic [6:0] i_min_duration_count,
	input wire logic i_latch_enable,
	input wire logic i_flags_read,
	output logic [7:0] o_flags,
	output logic o_event
);
	// ----------------------------------------
	// Threshold compare
	// ----------------------------------------
	logic [SAMPLE_W-1:0] mag [3];
	logic [SAMPLE_W-1:0] thr_scaled;
	logic [5:0] raw_hl;
	logic [5:0] enables;
	logic [5:0] hits;
	logic combined;

	// [R18] Scaled magnitude compare
	// One step is 256 codes shifted right by the full-scale setting (1/128 of full scale at setting 0), so the shift tracks the selected range
	always_comb begin
		thr_scaled = SAMPLE_W'({i_threshold_level, 8'h00} >> i_full_scale);
	end

	genvar ax;
	generate
		for (ax = 0; ax < 3; ax++) begin : g_axis
			logic signed [SAMPLE_W-1:0] s;
			assign s = (ax == 0) ? i_sample.x : (ax == 1) ? i_sample.y : i_sample.z;
			assign mag[ax] = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : s;
			// [R3] High compare
			assign raw_hl[2*ax+1] = mag[ax] > thr_scaled;
			// [R4] Low compare
			assign raw_hl[2*ax] = mag[ax] < thr_scaled;
		end
	endgenerate

	// [R5] Disabled axes masked
	assign enables = i_config[5:0];
	assign hits = raw_hl & enables;

	// [R1] [R2] Event combine
	always_comb begin
		unique case ({i_config.and_or_select, i_config.six_direction_enable})
			2'h0: combined = |hits;
			2'h2: combined = (enables != 6'h00) && ((raw_hl & enables) == enables);
			// Six direction: exactly one enabled high or low condition met
			default: combined = (enables != 6'h00) && ($countones(hits) == 1);
		endcase
	end

	// ----------------------------------------
	// Duration and flags
	// ----------------------------------------
	logic [6:0] dur_ff;
	logic [5:0] last_hits_ff;
	logic recognised;
	logic [5:0] det_hits;

	// [R17] Duration per sample
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dur_ff <= 7'h00;
			last_hits_ff <= 6'h00;
		end else if (i_sample.sample_valid) begin
			last_hits_ff <= hits;
			// Movement mode restarts the count when the direction changes
			if (!combined || (i_config.six_direction_enable && !i_config.and_or_select && hits != last_hits_ff))
				dur_ff <= 7'h00;
			else if (dur_ff != 7'h7F)
				dur_ff <= dur_ff + 7'h01;
		end
	end

	assign recognised = i_sample.sample_valid && combined && (dur_ff >= i_min_duration_count);
	assign det_hits = recognised ? hits : 6'h00;

	// [R7] [R8] [R10] [R11] [R15] Source flag update
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_flags <= 8'h00;
			o_event <= 1'b0;
		end else if (i_latch_enable) begin
			// A new event wins over the read that would clear it
			if (recognised) begin
				o_flags <= {1'b0, 1'b1, (i_flags_read ? 6'h00 : o_flags[5:0]) | det_hits};
				o_event <= 1'b1;
			end else if (i_flags_read) begin
				o_flags <= 8'h00;
				o_event <= 1'b0;
			end
		end else if (i_sample.sample_valid) begin
			o_flags <= {1'b0, recognised, det_hits};
			o_event <= recognised;
		end else if (i_flags_read) begin
			o_flags[6] <= 1'b0;
			o_event <= 1'b0;
		end
	end
endmodule : motion_event_unit

// File: src/dual_motion_event_generator.sv
// Top: register file of two motion event generators and interrupt pad routing
// Contract
// [R1] No six-direction: combine select 0 ORs enabled conditions, 1 ANDs them.
// [R2] Six-direction set: combine select 0 movement, 1 position recognition.
// [R3] High enable 1 requests event when axis magnitude exceeds threshold.
// [R4] Low enable 1 requests event when axis magnitude is below threshold.
// [R5] Enable 0 blocks that axis from any request.
// [R6] Configuration registers reset to zero: OR mode, all axes off.
// [R7] Active bit is 1 once an event has been generated.
// [R8] Six per-axis flags report their events, reset to zero.
// [R9] Source register read-only, bit 7 reads zero, writes ignored.
// [R10] Reading source clears active bit and deasserts its pad.
// [R11] Latched contents stay frozen until the source register is read; code ORs in flags of later events.
// [R12] Threshold is seven bits, resets zero, bit 7 reads zero.
// [R13] Minimum duration seven bits, resets zero, counted in output samples.
// [R14] Second generator duplicates the first with its own registers.
// [R15] Per-generator latch control holds flags until read; resets zero. Code takes it from inputs i_gen1_latch_enable/i_gen2_latch_enable, no reset.
// [R16] Two-bit pad route: own, OR of both, data ready, boot.
// [R17] Duration counts samples while condition holds; zero recognises at once.
// [R18] Threshold scaled by full scale; high and low share it.
module dual_motion_event_generator #(
	parameter int SAMPLE_W = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_write,
	input wire logic i_reg_read,
	input wire motion_event_pkg::axis_sample_t i_sample,
	input wire logic [1:0] i_full_scale,
	input wire logic i_gen1_latch_enable,
	input wire logic i_gen2_latch_enable,
	input wire logic [1:0] i_pad1_route_select,
	input wire logic [1:0] i_pad2_route_select,
	input wire logic i_data_ready,
	input wire logic i_boot_running,
	output logic [7:0] o_reg_rdata,
	output logic o_int1_pad,
	output logic o_int2_pad
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	motion_event_pkg::gen_config_t config_ff [2];
	logic [6:0] threshold_ff [2];
	logic [6:0] duration_ff [2];
	logic [7:0] flags [2];
	logic [1:0] gen_event;
	logic [1:0] flags_read;
	logic [1:0] latch_en;

	assign latch_en = {i_gen2_latch_enable, i_gen1_latch_enable};

	// [R14] Two identical generators
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_gen
			localparam logic [7:0] BASE = motion_event_pkg::GEN1_CONFIG_ADDR
				+ 8'(g) * motion_event_pkg::GEN_ADDR_STRIDE;
			localparam logic [7:0] FLAGS_A = BASE + 8'h01;
			localparam logic [7:0] THR_A = BASE + 8'h02;
			localparam logic [7:0] DUR_A = BASE + 8'h03;

			// [R10] Read strobe clears
			assign flags_read[g] = i_reg_read && (i_reg_addr == FLAGS_A);

			// [R6] [R12] [R13] Writable fields
			// [R9] Source address takes no write
			always_ff @(posedge i_core_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					config_ff[g] <= motion_event_pkg::REG_RESET;
					threshold_ff[g] <= 7'h00;
					duration_ff[g] <= 7'h00;
				end else if (i_reg_write) begin
					if (i_reg_addr == BASE)
						config_ff[g] <= i_reg_wdata;
					if (i_reg_addr == THR_A)
						threshold_ff[g] <= i_reg_wdata[motion_event_pkg::FIELD_W-1:0];
					if (i_reg_addr == DUR_A)
						duration_ff[g] <= i_reg_wdata[motion_event_pkg::FIELD_W-1:0];
				end
			end

			motion_event_unit #(
				.SAMPLE_W(SAMPLE_W)
			) u_unit (
				.i_core_clk(i_core_clk),
				.i_rst_b(i_rst_b),
				.i_sample(i_sample),
				.i_full_scale(i_full_scale),
				.i_config(config_ff[g]),
				.i_threshold_level(threshold_ff[g]),
				.i_min_duration_count(duration_ff[g]),
				.i_latch_enable(latch_en[g]),
				.i_flags_read(flags_read[g]),
				.o_flags(flags[g]),
				.o_event(gen_event[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [7:0] nxt_rdata;

	// Unmapped addresses read zero so the block can share the address space
	always_comb begin
		unique case (i_reg_addr)
			motion_event_pkg::GEN1_CONFIG_ADDR: nxt_rdata = config_ff[0];
			// [R9] Top bit zero
			motion_event_pkg::GEN1_FLAGS_ADDR: nxt_rdata = {1'b0, flags[0][6:0]};
			// [R12] Top bit zero
			motion_event_pkg::GEN1_THRESHOLD_ADDR: nxt_rdata = {1'b0, threshold_ff[0]};
			motion_event_pkg::GEN1_DURATION_ADDR: nxt_rdata = {1'b0, duration_ff[0]};
			motion_event_pkg::GEN2_CONFIG_ADDR: nxt_rdata = config_ff[1];
			motion_event_pkg::GEN2_FLAGS_ADDR: nxt_rdata = {1'b0, flags[1][6:0]};
			motion_event_pkg::GEN2_THRESHOLD_ADDR: nxt_rdata = {1'b0, threshold_ff[1]};
			motion_event_pkg::GEN2_DURATION_ADDR: nxt_rdata = {1'b0, duration_ff[1]};
			default: nxt_rdata = motion_event_pkg::REG_RESET;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_reg_rdata <= motion_event_pkg::REG_RESET;
		else if (i_reg_read)
			o_reg_rdata <= nxt_rdata;
	end

	// ----------------------------------------
	// Pad routing
	// ----------------------------------------
	function automatic logic route(input logic [1:0] sel, input logic own, input logic either,
		input logic dr, input logic boot);
		unique case (sel)
			motion_event_pkg::ROUTE_OWN: route = own;
			motion_event_pkg::ROUTE_EITHER: route = either;
			motion_event_pkg::ROUTE_DATA_READY: route = dr;
			motion_event_pkg::ROUTE_BOOT: route = boot;
		endcase
	endfunction : route

	// [R16] Pad source select
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_int1_pad <= 1'b0;
			o_int2_pad <= 1'b0;
		end else begin
			o_int1_pad <= route(i_pad1_route_select, gen_event[0], |gen_event, i_data_ready, i_boot_running);
			o_int2_pad <= route(i_pad2_route_select, gen_event[1], |gen_event, i_data_ready, i_boot_running);
		end
	end
endmodule : dual_motion_event_generator

// File: verif/axis_sample_source.sv
// Partner model: delivers one output sample of the three axes per call
module axis_sample_source (
	input wire logic i_core_clk,
	output motion_event_pkg::axis_sample_t o_sample
);
	timeunit 1ns;
	timeprecision 100ps;
	initial o_sample = '0;
	// Valid is a one-cycle pulse; the axis values simply hold afterwards
	task automatic send(input logic signed [15:0] x, input logic signed [15:0] y, input logic signed [15:0] z);
		o_sample = {1'b1, x, y, z};
		@(posedge i_core_clk);
		#2;
		o_sample.sample_valid = 1'b0;
		@(posedge i_core_clk);
		#2;
	endtask : send
endmodule : axis_sample_source

// File: verif/motion_event_sva.sv
// Checker: port-level assertions of the motion event generators
module motion_event_sva (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_read,
	input wire motion_event_pkg::axis_sample_t i_sample,
	input wire logic [1:0] i_pad1_route_select,
	input wire logic [1:0] i_pad2_route_select,
	input wire logic i_data_ready,
	input wire logic i_boot_running,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_int1_pad,
	input wire logic o_int2_pad
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	bit_seven_zero_a: assert property (i_reg_read && i_reg_addr inside {[8'h31:8'h33], [8'h35:8'h37]}
		|=> !o_reg_rdata[7]) else $error("bit 7 of read-only field not zero");
	unmapped_zero_a: assert property (i_reg_read && !(i_reg_addr inside {[8'h30:8'h37]})
		|=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!i_reg_read |=> $stable(o_reg_rdata)) else $error("read data moved");
	ready_route_a: assert property (i_pad1_route_select == 2'h2 |=> o_int1_pad == $past(i_data_ready))
		else $error("pad 1 not data ready");
	boot_route_a: assert property (i_pad2_route_select == 2'h3 |=> o_int2_pad == $past(i_boot_running))
		else $error("pad 2 not boot running");
	gen1_clear_a: assert property ((i_reg_read && i_reg_addr == 8'h31 && !i_sample.sample_valid)
		##1 (i_pad1_route_select == 2'h0) |=> !o_int1_pad) else $error("pad 1 not cleared by read");
	gen2_clear_a: assert property ((i_reg_read && i_reg_addr == 8'h35 && !i_sample.sample_valid)
		##1 (i_pad2_route_select == 2'h0) |=> !o_int2_pad) else $error("pad 2 not cleared by read");
	pad_cause_a: assert property ($rose(o_int1_pad) && $past(i_pad1_route_select) == 2'h0
		&& $past(i_pad1_route_select, 2) == 2'h0 |-> $past(i_sample.sample_valid, 2))
		else $error("pad 1 rose without sample");
	cover property (i_reg_read && i_reg_addr == 8'h31 && o_int1_pad);
	cover property ($rose(o_int2_pad));
	cover property (i_pad1_route_select == 2'h1 && o_int1_pad);
endmodule : motion_event_sva

// File: verif/dual_motion_event_generator_bench.sv
// Testbench: register and event sequences for both generators and pad routing
module dual_motion_event_generator_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_core_clk, i_rst_b, i_reg_write, i_reg_read, i_gen1_latch_enable, i_gen2_latch_enable;
	logic i_data_ready, i_boot_running, o_int1_pad, o_int2_pad, pad_g;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rd_v, b;
	logic [1:0] i_full_scale, i_pad1_route_select, i_pad2_route_select;
	motion_event_pkg::axis_sample_t i_sample;
	int fail_count = 0;
	int total_checks = 0;
	int g = 0;
	assign pad_g = (g == 0) ? o_int1_pad : o_int2_pad;
	dual_motion_event_generator dual_motion_event_generator_i (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata),
		.i_reg_write(i_reg_write),
		.i_reg_read(i_reg_read),
		.i_sample(i_sample),
		.i_full_scale(i_full_scale),
		.i_gen1_latch_enable(i_gen1_latch_enable),
		.i_gen2_latch_enable(i_gen2_latch_enable),
		.i_pad1_route_select(i_pad1_route_select),
		.i_pad2_route_select(i_pad2_route_select),
		.i_data_ready(i_data_ready),
		.i_boot_running(i_boot_running),
		.o_reg_rdata(o_reg_rdata),
		.o_int1_pad(o_int1_pad),
		.o_int2_pad(o_int2_pad)
	);
	axis_sample_source axis_sample_source_i (.i_core_clk(i_core_clk), .o_sample(i_sample));
	initial begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = ~i_core_clk;
	end
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task tk;
		@(posedge i_core_clk);
		#2;
	endtask : tk
	task wr(input logic [7:0] a, input logic [7:0] d);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_write = 1'b1;
		tk;
		i_reg_write = 1'b0;
		tk;
	endtask : wr
	task rd(input logic [7:0] a);
		i_reg_addr = a;
		i_reg_read = 1'b1;
		tk;
		i_reg_read = 1'b0;
		rd_v = o_reg_rdata;
		tk;
	endtask : rd
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(n, rd_v, e);
	endtask : rchk
	task x_hi(input logic [7:0] c);
		wr(b, c);
		axis_sample_source_i.send(16'h2000, 16'h0000, 16'h0000);
	endtask : x_hi
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	// Hang guard: the sequence is short, so a long stall is itself a fault
	initial begin
		repeat (20000) @(posedge i_core_clk);
		fail_count++;
		final_report;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{i_rst_b, i_reg_write, i_reg_read, i_gen1_latch_enable, i_gen2_latch_enable} = 5'h00;
		{i_data_ready, i_boot_running, i_full_scale, i_pad1_route_select, i_pad2_route_select} = 8'h00;
		{i_reg_addr, i_reg_wdata} = 16'h0000;
		repeat (20) tk;
		i_rst_b = 1'b1;
		tk;
		for (int a = 8'h30; a <= 8'h38; a++) rchk("reset value", a[7:0], 8'h00);
		$display("test reset done");
		for (g = 0; g < 2; g++) begin
			b = 8'h30 + 8'(g * 4);
			wr(b + 8'h02, 8'hFF);
			rchk("threshold", b + 8'h02, 8'h7F);
			wr(b + 8'h03, 8'hFF);
			rchk("duration", b + 8'h03, 8'h7F);
			wr(b + 8'h01, 8'hFF);
			rchk("flags write", b + 8'h01, 8'h00);
			wr(b + 8'h03, 8'h00);
			wr(b + 8'h02, 8'h10);
			x_hi(8'h00);
			rchk("disabled", b + 8'h01, 8'h00);
			wr(b, 8'h02);
			axis_sample_source_i.send(-16'sh2000, 16'h0000, 16'h0000);
			chk("pad set", {7'h00, pad_g}, 8'h01);
			rchk("x high", b + 8'h01, 8'h42);
			tk;
			chk("pad clear", {7'h00, pad_g}, 8'h00);
			wr(b, 8'h01);
			axis_sample_source_i.send(16'h0100, 16'h0000, 16'h0000);
			rchk("x low", b + 8'h01, 8'h41);
			x_hi(8'h8A);
			rd(b + 8'h01);
			chk("and partial", rd_v & 8'h40, 8'h00);
			axis_sample_source_i.send(16'h2000, 16'h2000, 16'h0000);
			rchk("and all", b + 8'h01, 8'h4A);
			for (int m = 0; m < 2; m++) begin
				x_hi(m ? 8'hC2 : 8'h42);
				rd(b + 8'h01);
				chk("six direction", rd_v & 8'h40, 8'h40);
			end
			x_hi(8'h02);
			rd(b + 8'h01);
			wr(b + 8'h03, 8'h02);
			axis_sample_source_i.send(16'h0000, 16'h0000, 16'h0000);
			repeat (2) axis_sample_source_i.send(16'h2000, 16'h0000, 16'h0000);
			chk("duration early", {7'h00, pad_g}, 8'h00);
			x_hi(8'h02);
			chk("duration met", {7'h00, pad_g}, 8'h01);
			rd(b + 8'h01);
			wr(b + 8'h03, 8'h00);
			{i_gen2_latch_enable, i_gen1_latch_enable} = 2'(1 << g);
			x_hi(8'h02);
			axis_sample_source_i.send(16'h0000, 16'h0000, 16'h0000);
			chk("latched pad", {7'h00, pad_g}, 8'h01);
			rchk("latched flags", b + 8'h01, 8'h42);
			{i_gen2_latch_enable, i_gen1_latch_enable} = 2'h0;
			$display("test generator %0d done", g + 1);
		end
		g = 0;
		{i_pad1_route_select, i_data_ready} = 3'h5;
		repeat (2) tk;
		chk("pad data ready", {7'h00, o_int1_pad}, 8'h01);
		{i_pad2_route_select, i_boot_running} = 3'h7;
		repeat (2) tk;
		chk("pad boot", {7'h00, o_int2_pad}, 8'h01);
		i_pad1_route_select = 2'h1;
		// Generator 1 kept quiet so only the OR path can raise pad 1
		wr(8'h30, 8'h00);
		b = 8'h34;
		x_hi(8'h02);
		chk("pad either", {7'h00, o_int1_pad}, 8'h01);
		$display("test routing done");
		// Wider range halves the raw threshold, so 0C00h sits between the two
		i_full_scale = 2'h1;
		axis_sample_source_i.send(16'h0C00, 16'h0000, 16'h0000);
		chk("range wide", {7'h00, o_int1_pad}, 8'h01);
		i_full_scale = 2'h0;
		axis_sample_source_i.send(16'h0C00, 16'h0000, 16'h0000);
		chk("range narrow", {7'h00, o_int1_pad}, 8'h00);
		$display("test range done");
		final_report;
	end
endmodule : dual_motion_event_generator_bench

bind dual_motion_event_generator motion_event_sva motion_event_sva_i (
	.i_core_clk(i_core_clk),
	.i_rst_b(i_rst_b),
	.i_reg_addr(i_reg_addr),
	.i_reg_read(i_reg_read),
	.i_sample(i_sample),
	.i_pad1_route_select(i_pad1_route_select),
	.i_pad2_route_select(i_pad2_route_select),
	.i_data_ready(i_data_ready),
	.i_boot_running(i_boot_running),
	.o_reg_rdata(o_reg_rdata),
	.o_int1_pad(o_int1_pad),
	.o_int2_pad(o_int2_pad)
);
